// >>> hw/fault_supervisor.sv
// Purpose: underload and thermal fault supervision for twelve channels
// Assumes: comparator and select pins are asynchronous to ref_clk_i
// Notes: overcurrent latch lives outside; only its codes and status bit are reported here
module fault_supervisor #(
  parameter int ULD_TERM = fault_pkg::ULD_DELAY_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_i,
  input wire logic chip_select_bar_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic [fault_pkg::NUM_CH-1:0] high_side_req_i,
  input wire logic [fault_pkg::NUM_CH-1:0] low_side_req_i,
  input wire logic [fault_pkg::NUM_CH-1:0] underload_det_i,
  input wire logic [fault_pkg::NUM_CH-1:0] warn_cmp_i,
  input wire logic [fault_pkg::NUM_CH-1:0] shutdown_cmp_i,
  input wire logic [fault_pkg::NUM_CH-1:0] overcurrent_i,
  output logic [fault_pkg::NUM_CH-1:0] high_side_driver_o,
  output logic [fault_pkg::NUM_CH-1:0] low_side_driver_o,
  output logic [2*fault_pkg::NUM_CH-1:0] half_bridge_fault_code_o,
  output logic underload_flag_o,
  output logic thermal_warning_flag_o,
  output logic thermal_shutdown_flag_o,
  output logic underload_shutdown_enable_o,
  output logic channel_group_select_o
);
  import fault_pkg::*;

  initial begin
    if (ULD_TERM < 1) begin
      $error("fault_supervisor: ULD_TERM must be at least 1");
    end
  end

  // Channel mask of a group
  function automatic logic [NUM_CH-1:0] group_mask(input logic grp);
    logic [NUM_CH-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      m[i] = ((i / GROUP_CH) == int'(grp));
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous pins

  logic [NUM_CH-1:0] uld_s1_q, uld_s2_q;
  logic [NUM_CH-1:0] tw_s1_q, tw_s2_q;
  logic [NUM_CH-1:0] tsd_s1_q, tsd_s2_q;
  logic csb_s1_q, csb_s2_q, csb_d3_q;

  // Two flops on every comparator and on chip select
  always_ff @(posedge ref_clk_i) begin
    uld_s1_q <= underload_det_i;
    uld_s2_q <= uld_s1_q;
    tw_s1_q <= warn_cmp_i;
    tw_s2_q <= tw_s1_q;
    tsd_s1_q <= shutdown_cmp_i;
    tsd_s2_q <= tsd_s1_q;
    csb_s1_q <= chip_select_bar_i;
    csb_s2_q <= csb_s1_q;
    csb_d3_q <= csb_s2_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial link and frame end

  frame_s frame;
  logic [CNT_W-1:0] bit_count;
  status_s status_q, status_d;
  logic tsd_flag;

  serial_link u_link (
    .serial_clock_i(serial_clock_i),
    .chip_select_bar_i(chip_select_bar_i),
    .serial_in_i(serial_in_i),
    .tsd_level_i(tsd_flag),
    .status_i(status_q),
    .frame_o(frame),
    .bit_count_o(bit_count),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o)
  );

  // Frame ends on synchronised select rise; word is stable by then
  wire logic frame_end = csb_s2_q & ~csb_d3_q;
  wire logic frame_ok = frame_end &&
                        (bit_count == CNT_W'(FRAME_BITS));
  wire logic clear_go = frame_ok & frame.clear_req;
  wire logic [NUM_CH-1:0] clear_mask =
    clear_go ? group_mask(frame.group_sel) : '0;

  logic uld_en_q, group_q;

  // Configuration bits follow each valid frame
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      uld_en_q <= RST_ULD_EN;
      group_q <= RST_GROUP;
    end else if (frame_ok) begin
      uld_en_q <= frame.uld_en;
      group_q <= frame.group_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Underload qualification

  logic tmr_running, tmr_expire;

  // One timer for all channels; starts only from idle
  uld_delay_timer #(
    .TERM(ULD_TERM)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .start_i(|uld_s2_q),
    .running_o(tmr_running),
    .expire_o(tmr_expire)
  );

  logic [NUM_CH-1:0] uld_latch_q, tsd_latch_q;
  logic uld_flag_q;

  // Channels still under load at expiry are shut, whatever start time
  wire logic [NUM_CH-1:0] uld_hit =
    (tmr_expire && uld_en_q) ? uld_s2_q : '0;

  // Per-channel underload latch; a new hit wins over a clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      uld_latch_q <= '0;
      uld_flag_q <= 1'b0;
    end else begin
      uld_latch_q <= (uld_latch_q & ~clear_mask) | uld_hit;
      uld_flag_q <= (uld_flag_q & ~clear_go) | (|uld_hit);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Thermal supervision

  // Shutdown clear needs both the request and a cooled comparator
  wire logic [NUM_CH-1:0] tsd_release = clear_mask & ~tsd_s2_q;

  // Per-channel thermal shutdown latch; comparator set wins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tsd_latch_q <= '0;
    end else begin
      tsd_latch_q <= (tsd_latch_q & ~tsd_release) | tsd_s2_q;
    end
  end

  assign tsd_flag = |tsd_latch_q;

  //////////////////////////////////////////////////////////////////////////
  // Outputs and status

  // Drivers off while any latched fault; warning plays no part
  wire logic [NUM_CH-1:0] ch_off = uld_latch_q | tsd_latch_q;
  logic [NUM_CH-1:0] hs_q, ls_q;

  // Driver registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hs_q <= '0;
      ls_q <= '0;
    end else begin
      hs_q <= high_side_req_i & ~ch_off;
      ls_q <= low_side_req_i & ~ch_off;
    end
  end

  logic [2*NUM_CH-1:0] code_q, code_d;

  // Overcurrent code outranks the underload code
  always_comb begin
    code_d = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (overcurrent_i[i]) begin
        code_d[2*i +: 2] = CODE_OC;
      end else if (uld_latch_q[i]) begin
        code_d[2*i +: 2] = CODE_ULD;
      end else begin
        code_d[2*i +: 2] = CODE_NONE;
      end
    end
  end

  wire logic tw_now = |tw_s2_q;
  wire logic [11:0] grp_codes =
    group_q ? code_q[23:12] : code_q[11:0];

  // Status word for the next frame
  always_comb begin
    status_d.tsd = tsd_flag;
    status_d.tw = tw_now;
    status_d.uld = uld_flag_q;
    status_d.ocs = |overcurrent_i;
    status_d.codes = grp_codes;
  end

  logic tw_q;

  // Status frozen while selected so the frame reads one snapshot
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      code_q <= '0;
      tw_q <= 1'b0;
      status_q <= '0;
    end else begin
      code_q <= code_d;
      tw_q <= tw_now;
      if (csb_s2_q && chip_select_bar_i) begin
        status_q <= status_d;
      end
    end
  end

  assign high_side_driver_o = hs_q;
  assign low_side_driver_o = ls_q;
  assign half_bridge_fault_code_o = code_q;
  assign underload_flag_o = uld_flag_q;
  assign thermal_warning_flag_o = tw_q;
  assign thermal_shutdown_flag_o = tsd_flag;
  assign underload_shutdown_enable_o = uld_en_q;
  assign channel_group_select_o = group_q;

endmodule

// >>> hw/fault_pkg.sv
// Purpose: shared constants and types for the fault supervision block
// Assumes: twelve half-bridge channels in two groups of six
// Notes: frame bit positions are local choices of this design
package fault_pkg;

  localparam int NUM_CH = 12;
  localparam int GROUP_CH = 6;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;

  // Command frame field positions, most significant bit sent first
  localparam int FLD_CLEAR = 15;
  localparam int FLD_GROUP = 14;
  localparam int FLD_ULD_EN = 13;

  // Per-channel two-bit fault codes
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OC = 2'h1;
  localparam logic [1:0] CODE_ULD = 2'h2;

  // Underload qualifying delay, in ns, and clock rate
  localparam int CLK_MHZ = 25;
  localparam int ULD_DELAY_NS = 200000;
  localparam int ULD_DELAY_CYC = (ULD_DELAY_NS * CLK_MHZ) / 1000;

  // Values after reset
  localparam logic RST_ULD_EN = 1'b0;
  localparam logic RST_GROUP = 1'b0;

  // Timer states
  typedef enum logic {TMR_IDLE, TMR_RUN} tmr_state_e;

  // Command frame as shifted in
  typedef struct packed {
    logic clear_req;
    logic group_sel;
    logic uld_en;
    logic [12:0] other;
  } frame_s;

  // Status word as shifted out, thermal shutdown leads
  typedef struct packed {
    logic tsd;
    logic tw;
    logic uld;
    logic ocs;
    logic [11:0] codes;
  } status_s;

endpackage

// >>> hw/uld_delay_timer.sv
// Purpose: shared underload qualifying delay timer
// Assumes: start_i is a same-clock level
// Notes: expire_o is a one-cycle pulse
module uld_delay_timer #(
  parameter int TERM = 5000
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  output logic running_o,
  output logic expire_o
);
  import fault_pkg::*;

  localparam int W = $clog2(TERM + 1);

  initial begin
    if (TERM < 1) begin
      $error("uld_delay_timer: TERM must be at least 1");
    end
  end

  tmr_state_e state_q, state_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic expire_q, expire_d;

  wire logic at_term = (cnt_q == W'(TERM - 1));

  // Next state: idle until any underload, then count to terminal
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    expire_d = 1'b0;
    case (state_q)
      TMR_IDLE: begin
        cnt_d = '0;
        if (start_i) begin
          state_d = TMR_RUN;
        end
      end
      TMR_RUN: begin
        if (at_term) begin
          state_d = TMR_IDLE;
          expire_d = 1'b1;
        end else begin
          cnt_d = cnt_q + W'(1);
        end
      end
      default: state_d = TMR_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= TMR_IDLE;
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

  assign running_o = (state_q == TMR_RUN);
  assign expire_o = expire_q;

endmodule

// >>> hw/serial_link.sv
// Purpose: serial-clock side of the control frame
// Assumes: serial clock idles low and stops while chip select is high
// Notes: frame word and count hold after the frame for the core to read
module serial_link (
  input wire logic serial_clock_i,
  input wire logic chip_select_bar_i,
  input wire logic serial_in_i,
  input wire logic tsd_level_i,
  input fault_pkg::status_s status_i,
  output fault_pkg::frame_s frame_o,
  output logic [fault_pkg::CNT_W-1:0] bit_count_o,
  output logic serial_out_o,
  output logic serial_out_oe_o
);
  import fault_pkg::*;

  logic first_edge_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [CNT_W-1:0] cnt_q;

  // Marks the first rising serial clock of a frame; cleared by select
  always_ff @(posedge serial_clock_i or posedge chip_select_bar_i) begin
    if (chip_select_bar_i) begin
      first_edge_q <= 1'b0;
    end else begin
      first_edge_q <= 1'b1;
    end
  end

  // Shift in MSB first; count restarts on the first edge of a frame
  always_ff @(posedge serial_clock_i) begin
    shift_q <= {shift_q[FRAME_BITS-2:0], serial_in_i};
    if (!first_edge_q) begin
      cnt_q <= CNT_W'(1);
    end else if (cnt_q != CNT_W'(FRAME_BITS)) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  wire logic [3:0] out_idx = 4'(FRAME_BITS - 1) - cnt_q[3:0];
  wire logic shift_bit = (cnt_q < CNT_W'(FRAME_BITS)) ?
                         status_i[out_idx] : 1'b0;

  // Latched shutdown flag leads until the first rising edge
  assign serial_out_o = chip_select_bar_i ? 1'b0 :
                        (first_edge_q ? shift_bit : tsd_level_i);
  assign serial_out_oe_o = ~chip_select_bar_i;
  assign frame_o = frame_s'(shift_q);
  assign bit_count_o = cnt_q;

endmodule

// >>> dv/fault_supervisor_props.sv
// Purpose: port-level checks of the fault supervisor
// Assumes: warning comparator rises before shutdown comparator
// Notes: all checks run on ref_clk_i and stop during srst_i
module fault_supervisor_props #(
  parameter int ULD_TERM = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_i,
  input wire logic chip_select_bar_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic [fault_pkg::NUM_CH-1:0] high_side_req_i,
  input wire logic [fault_pkg::NUM_CH-1:0] overcurrent_i,
  input wire logic [fault_pkg::NUM_CH-1:0] high_side_driver_o,
  input wire logic [fault_pkg::NUM_CH-1:0] low_side_driver_o,
  input wire logic [2*fault_pkg::NUM_CH-1:0] half_bridge_fault_code_o,
  input wire logic underload_flag_o,
  input wire logic thermal_warning_flag_o,
  input wire logic thermal_shutdown_flag_o,
  input wire logic underload_shutdown_enable_o
);
  import fault_pkg::*;
  wire logic [NUM_CH-1:0] uld_ch;
  wire logic [NUM_CH-1:0] bad_ch;
  logic no_edge_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////
  // Marks the span from select fall to first link clock
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || chip_select_bar_i) no_edge_q <= 1'b1;
    else if (serial_clock_i) no_edge_q <= 1'b0;
  end
  // Per-channel code decode and priority check
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign uld_ch[i] = half_bridge_fault_code_o[2*i+:2] == CODE_ULD;
    assign bad_ch[i] = half_bridge_fault_code_o[2*i+:2] == 2'h3;
    ovc_prio_a: assert property (
      $past(overcurrent_i[i]) && !$past(srst_i) |-> !uld_ch[i])
      else $error("underload code shown over overcurrent");
  end
  ////////////////////////////////////////////////////////////
  oe_follow_a: assert property (
    serial_out_oe_o == !chip_select_bar_i) else $error("enable off select");
  so_idle_a: assert property (
    chip_select_bar_i |-> !serial_out_o) else $error("output busy idle");
  tsd_out_a: assert property (
    !chip_select_bar_i && no_edge_q && !serial_clock_i
    && $stable(thermal_shutdown_flag_o)
    && $past(thermal_shutdown_flag_o, 4) == thermal_shutdown_flag_o
    |-> serial_out_o == thermal_shutdown_flag_o)
    else $error("leading bit not shutdown flag");
  uld_off_a: assert property (
    !(|((high_side_driver_o | low_side_driver_o) & uld_ch)))
    else $error("driver on in underload channel");
  uld_flag_a: assert property (
    $rose(|uld_ch) |-> underload_flag_o) else $error("flag missing");
  uld_gate_a: assert property (
    $rose(underload_flag_o) |-> $past(underload_shutdown_enable_o))
    else $error("underload latched while disabled");
  code_legal_a: assert property (
    bad_ch == '0) else $error("illegal fault code");
  tw_keep_a: assert property (
    $rose(thermal_shutdown_flag_o) |-> thermal_warning_flag_o)
    else $error("warning dropped at shutdown");
  drv_follow_a: assert property (
    !thermal_shutdown_flag_o && !$past(thermal_shutdown_flag_o)
    && half_bridge_fault_code_o == '0 && $past(overcurrent_i) == '0
    && !$past(srst_i) |-> high_side_driver_o == $past(high_side_req_i))
    else $error("driver differs from request");
endmodule

bind fault_supervisor fault_supervisor_props #(.ULD_TERM(ULD_TERM)) props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .serial_clock_i(serial_clock_i),
  .chip_select_bar_i(chip_select_bar_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .high_side_req_i(high_side_req_i),
  .overcurrent_i(overcurrent_i), .high_side_driver_o(high_side_driver_o),
  .low_side_driver_o(low_side_driver_o),
  .half_bridge_fault_code_o(half_bridge_fault_code_o),
  .underload_flag_o(underload_flag_o),
  .thermal_warning_flag_o(thermal_warning_flag_o),
  .thermal_shutdown_flag_o(thermal_shutdown_flag_o),
  .underload_shutdown_enable_o(underload_shutdown_enable_o));

// >>> dv/spi_host_model.sv
// Purpose: host side of the serial control frame
// Assumes: link clock 80 ns, idles low, stands still between frames
// Notes: xfer returns the word read on serial_out, MSB first
module spi_host_model (
  output logic serial_clock_o,
  output logic chip_select_bar_o,
  output logic serial_in_o,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels; select rises once so the link's first-edge mark clears
  initial begin
    serial_clock_o = 1'b0;
    chip_select_bar_o = 1'b0;
    serial_in_o = 1'b0;
    #1;
    chip_select_bar_o = 1'b1;
  end
  // One frame, data set and output sampled while clock low
  task automatic xfer(input logic [15:0] w, output logic [15:0] rx);
    #13;
    serial_clock_o = 1'b0;
    serial_in_o = 1'b0;
    #40;
    chip_select_bar_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in_o = w[i];
      #40;
      rx[i] = serial_out_oe_i ? serial_out_i : 1'bx;
      serial_clock_o = 1'b1;
      #40;
      serial_clock_o = 1'b0;
    end
    #40;
    chip_select_bar_o = 1'b1;
    serial_in_o = 1'b0; // Line is pulled down once released
    #200; // Select-high gap for the core to apply the frame
  endtask
endmodule

// >>> dv/fault_supervisor_tb.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: underload delay shortened to TERM cycles
// Notes: expectations come from a per-channel latch model
module fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_pkg::*;
  localparam int TERM = 8;
  logic ref_clk, srst, sclk, chip_select_bar, si, so, so_oe, uld_fl, tw_fl, tsd_fl;
  logic en_o, grp_o;
  logic [NUM_CH-1:0] hs_req, ls_req, uld, warn, sdn, oc, hs, ls, exp_off;
  logic [2*NUM_CH-1:0] code;
  logic [15:0] rx;
  int bad_count, n_checks, seed;
  int exp_code[NUM_CH];
  fault_supervisor #(.ULD_TERM(TERM)) dut (
    .ref_clk_i(ref_clk), .srst_i(srst), .serial_clock_i(sclk),
    .chip_select_bar_i(chip_select_bar), .serial_in_i(si), .serial_out_o(so),
    .serial_out_oe_o(so_oe), .high_side_req_i(hs_req),
    .low_side_req_i(ls_req), .underload_det_i(uld), .warn_cmp_i(warn),
    .shutdown_cmp_i(sdn), .overcurrent_i(oc), .high_side_driver_o(hs),
    .low_side_driver_o(ls), .half_bridge_fault_code_o(code),
    .underload_flag_o(uld_fl), .thermal_warning_flag_o(tw_fl),
    .thermal_shutdown_flag_o(tsd_fl), .underload_shutdown_enable_o(en_o),
    .channel_group_select_o(grp_o));
  spi_host_model host (.serial_clock_o(sclk), .chip_select_bar_o(chip_select_bar),
    .serial_in_o(si), .serial_out_i(so), .serial_out_oe_i(so_oe));
  ////////////////////////////////////////////////////////////
  // Core clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Frame with clear, group and enable bits, then settle
  task automatic frame(input logic [2:0] f);
    host.xfer({f, 13'h0}, rx);
    wt(8);
  endtask
  task automatic rnd();
    hs_req = 12'($random(seed));
    ls_req = 12'($random(seed));
    wt(2);
  endtask
  // Compare codes and drivers against the latch model
  task automatic chk_core();
    logic [2*NUM_CH-1:0] ec;
    for (int i = 0; i < NUM_CH; i++) ec[2*i+:2] = exp_code[i][1:0];
    cmp(code, ec);
    cmp(hs, hs_req & ~exp_off);
    cmp(ls, ls_req & ~exp_off);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1;
    {hs_req, ls_req, uld, warn, sdn, oc, exp_off} = '0;
    bad_count = 0;
    n_checks = 0;
    seed = 81620;
    foreach (exp_code[i]) exp_code[i] = 0;
    wt(12);
    srst = 1'b0;
    wt(3);
    cmp({uld_fl, tw_fl, tsd_fl, en_o, grp_o}, 0);
    chk_core();
    frame(3'b001);
    cmp(en_o, 1'b1);
    rnd();
    {oc[4], uld[4], uld[2]} = 3'b111;
    wt(7);
    uld[3] = 1'b1;
    wt(8);
    exp_code[2] = 2;
    exp_code[3] = 2;
    exp_code[4] = 1;
    exp_off[4:2] = 3'b111;
    chk_core();
    cmp(uld_fl, 1'b1);
    frame(3'b111);
    chk_core();
    {oc[4], uld[4], uld[3]} = 3'b000;
    wt(3);
    frame(3'b101);
    cmp(code[9:6], 0);
    cmp(hs[4:3], hs_req[4:3]);
    wt(20);
    {exp_code[3], exp_code[4]} = {32'd0, 32'd0};
    exp_off[4:3] = 2'b00;
    chk_core();
    uld[2] = 1'b0;
    wt(3);
    frame(3'b101);
    exp_code[2] = 0;
    exp_off[2] = 1'b0;
    chk_core();
    cmp(uld_fl, 1'b0);
    frame(3'b000);
    cmp(en_o, 1'b0);
    uld[5] = 1'b1;
    wt(25);
    chk_core();
    cmp(uld_fl, 1'b0);
    uld[5] = 1'b0;
    rnd();
    warn[7] = 1'b1;
    wt(6);
    cmp(tw_fl, 1'b1);
    chk_core();
    sdn[7] = 1'b1;
    wt(6);
    exp_off[7] = 1'b1;
    chk_core();
    cmp({tw_fl, tsd_fl}, 2'b11);
    frame(3'b010);
    cmp(rx, 16'hC000);
    cmp(grp_o, 1'b1);
    frame(3'b100);
    cmp(tsd_fl, 1'b1);
    frame(3'b110);
    cmp(tsd_fl, 1'b1);
    sdn[7] = 1'b0;
    wt(4);
    frame(3'b110);
    exp_off[7] = 1'b0;
    cmp(tsd_fl, 1'b0);
    chk_core();
    warn[7] = 1'b0;
    wt(6);
    cmp(tw_fl, 1'b0);
    frame(3'b010);
    cmp(rx, 16'h0000);
    print_verdict();
  end
  // Watchdog against a hung sequence
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
